//--- tis_map.svh
// register offsets, field positions, reset values, boot addresses and sizes
`ifndef TIS_MAP_SVH
`define TIS_MAP_SVH
`define TIS_OFF_CORE       12'h000
`define TIS_OFF_INTCTL     12'h004
`define TIS_OFF_IFLAG      12'h008
`define TIS_OFF_IEN        12'h00C
`define TIS_OFF_IPRIO      12'h010
`define TIS_OFF_STACK_LIMIT_REG      12'h014
`define TIS_OFF_RSTCTL     12'h018
`define TIS_OFF_STAT       12'h01C
`define TIS_BIT_OVA_EN     10
`define TIS_BIT_OVB_EN     9
`define TIS_BIT_COV_EN     8
`define TIS_BIT_MATH       4
`define TIS_BIT_ADDR       3
`define TIS_BIT_STACK      2
`define TIS_BIT_OSC        1
`define TIS_BIT_CONFLICT   15
`define TIS_BIT_BADOP      14
`define TIS_BIT_WDT        4
`define TIS_BIT_BOR        1
`define TIS_LVL_MATH       4'hB
`define TIS_LVL_ADDR       4'hC
`define TIS_LVL_STACK      4'hD
`define TIS_LVL_OSC        4'hE
`define TIS_SP_FLOOR       16'h0800
`define TIS_STACK_LIMIT_REG_RST      16'hFFFF
`define TIS_IPRIO_RST      32'h44444444
`define TIS_BOOT_ADDR0     24'h000000
`define TIS_BOOT_ADDR1     24'h000002
`define TIS_NIRQ           8
`define TIS_DEPTH          8
`endif

//--- tis_pkg.sv
// types shared by the trap and interrupt sequencer
package tis_pkg;
   typedef enum logic [1:0] {
      TIS_F0  = 2'b00,
      TIS_F1  = 2'b01,
      TIS_RUN = 2'b11,
      TIS_RSV = 2'b10
   } tis_state_e;
   typedef logic [3:0] tis_lvl_t;
endpackage : tis_pkg

//--- tis_core.sv
// trap and interrupt sequencer with apb register access
//
// Contract
// RULE_01 - any reset restarts fetching at address zero
// RULE_02 - execute boot jump, continue at target word
// RULE_03 - six error conditions force the reset path; code uses five: wdt, uninit ptr, bad opcode, brown-out, conflict
// RULE_04 - flushed illegal opcode raises no reset
// RULE_05 - traps use fixed levels eight to fifteen
// RULE_06 - level seven blocks interrupts, traps still run
// RULE_07 - trapping instruction completes before trap processing
// RULE_08 - divide by zero aborts and raises math trap
// RULE_09 - enabled accumulator overflows, bad shifts raise math
// RULE_10 - bad accesses and fetches raise address trap
// RULE_11 - stack pointer outside limits raises stack trap
// RULE_12 - oscillator failure raises oscillator trap
// RULE_13 - soft traps take two cycles like interrupts
// RULE_14 - hard traps halt until acknowledged and processed
// RULE_15 - higher trap preempts, lower stays pending
// RULE_16 - same cycle traps resolved by fixed priority
// RULE_17 - lower hard trap conflict resets, sets flag
// RULE_18 - math and osc flags uncleared while cause persists
// RULE_19 - flags sampled each cycle, enabled flags request
// RULE_20 - interrupt only above current priority level
// RULE_21 - accept pushes pc and status, raises level
// RULE_22 - trap bit set only while trap executes
// RULE_23 - return pops pc and level, flags kept
`timescale 1ns/1ps
`include "tis_map.svh"

module tis_core
   import tis_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        instr_done,
   input  wire logic [23:0] cur_pc,
   input  wire logic        fetch_valid,
   input  wire logic [23:0] fetch_data,
   input  wire logic        return_from_interrupt_op,
   input  wire logic        div_zero,
   input  wire logic [1:0]  acc_ovf31,
   input  wire logic        acc_guard_used,
   input  wire logic [1:0]  acc_ovf39,
   input  wire logic        sat_off,
   input  wire logic        shift_over,
   input  wire logic        misaligned,
   input  wire logic        unimpl_read,
   input  wire logic        vector_fetch,
   input  wire logic        unimpl_branch,
   input  wire logic        sp_load,
   input  wire logic [15:0] sp_value,
   input  wire logic        osc_fail_pin,
   input  wire logic        wdt_timeout,
   input  wire logic        uninit_ptr,
   input  wire logic        illegal_op,
   input  wire logic        op_flushed,
   input  wire logic        brown_out,
   input  wire logic [7:0]  irq_events,
   output logic             fetch_req,
   output logic      [23:0] fetch_addr,
   output logic             pc_load,
   output logic      [23:0] pc_value,
   output logic             exc_take,
   output logic      [4:0]  exc_vector,
   output logic             push_req,
   output logic      [23:0] push_pc,
   output logic      [7:0]  push_srl,
   output logic             cpu_halt,
   output logic             core_rst_req
);

   tis_state_e state;
   tis_lvl_t   cpu_priority_level;
   logic [15:0] interrupt_control_one;
   logic [7:0]  irq_flag_regs;
   logic [7:0]  irq_enable_regs;
   logic [31:0] irq_prio;
   logic [15:0] stack_limit_reg;
   logic [15:0] reset_control_reg;
   logic [7:0]  trap_pend;
   logic [2:0]  osc_sync;
   logic        osc_fail;
   logic        srst;
   tis_lvl_t    eval_lvl;
   logic [4:0]  eval_id;
   logic        eval_vld;
   logic [23:0] stk_pc  [0:`TIS_DEPTH-1];
   tis_lvl_t    stk_lvl [0:`TIS_DEPTH-1];
   logic [2:0]  sp;

   // apb decode
   wire apb_setup  = psel & ~penable;
   wire apb_access = psel & penable & pready;
   wire apb_wr     = apb_access & pwrite;
   wire sel_core   = paddr == `TIS_OFF_CORE;
   wire sel_ictl   = paddr == `TIS_OFF_INTCTL;
   wire sel_iflag  = paddr == `TIS_OFF_IFLAG;
   wire sel_ien    = paddr == `TIS_OFF_IEN;
   wire sel_iprio  = paddr == `TIS_OFF_IPRIO;
   wire sel_stack_limit_reg  = paddr == `TIS_OFF_STACK_LIMIT_REG;
   wire sel_rst    = paddr == `TIS_OFF_RSTCTL;
   wire sel_stat   = paddr == `TIS_OFF_STAT;
   wire sel_any    = sel_core | sel_ictl | sel_iflag | sel_ien |
                     sel_iprio | sel_stack_limit_reg | sel_rst | sel_stat;
   wire trap_priority_bit = cpu_priority_level[3]; // RULE_22
   wire [31:0] rd_mux =
      sel_core  ? {28'h0000000, cpu_priority_level} :
      sel_ictl  ? {16'h0000, interrupt_control_one} :
      sel_iflag ? {24'h000000, irq_flag_regs} :
      sel_ien   ? {24'h000000, irq_enable_regs} :
      sel_iprio ? irq_prio :
      sel_stack_limit_reg ? {16'h0000, stack_limit_reg} :
      sel_rst   ? {16'h0000, reset_control_reg} :
      sel_stat  ? {16'h0000, trap_pend, 2'b00, sp, cpu_halt,
                   trap_priority_bit, 1'b0} :
                  32'h00000000;

   // trap detection; the source reports at the offending instruction
   wire math_ev  = div_zero | shift_over | // RULE_08 RULE_09
      (acc_ovf31[0] & ~acc_guard_used &
       interrupt_control_one[`TIS_BIT_OVA_EN]) |
      (acc_ovf31[1] & ~acc_guard_used &
       interrupt_control_one[`TIS_BIT_OVB_EN]) |
      (|acc_ovf39 & sat_off & interrupt_control_one[`TIS_BIT_COV_EN]);
   wire addr_ev  = misaligned | unimpl_read | vector_fetch |
                   unimpl_branch; // RULE_10
   wire stack_ev = sp_load & ((sp_value > stack_limit_reg) |
                   (sp_value < `TIS_SP_FLOOR)); // RULE_11
   // one pulse as the filtered failure rises, so a held failure traps once
   wire osc_ev   = (osc_sync[2] == osc_sync[1]) & osc_sync[2] &
                   ~osc_fail; // RULE_12
   wire [7:0] new_trap = {1'b0, osc_ev, stack_ev, addr_ev, math_ev,
                          3'b000}; // RULE_05

   // a new hard trap below a pending or running higher trap
   logic [7:0] above;
   logic       conflict;
   always_comb begin
      above    = 8'h00;
      conflict = 1'b0;
      for (int i = 4; i < 8; i++) begin
         above = 8'hFF << (i + 1);
         if (new_trap[i] && ((trap_pend & above) != 8'h00 ||
             (trap_priority_bit && cpu_priority_level[2:0] > i[2:0])))
            conflict = 1'b1; // RULE_17 RULE_03
      end
   end
   wire bad_op   = uninit_ptr |
                   (illegal_op & instr_done & ~op_flushed); // RULE_04
   wire err_rst  = wdt_timeout | bad_op | brown_out |
                   conflict; // RULE_03

   // highest pending source: traps first, then enabled interrupts
   wire [7:0] irq_req = irq_flag_regs & irq_enable_regs; // RULE_19
   logic [3:0] best_lvl;
   logic [4:0] best_id;
   logic       best_vld;
   always_comb begin
      best_lvl = 4'h0;
      best_id  = 5'h00;
      best_vld = 1'b0;
      for (int i = 0; i < `TIS_NIRQ; i++) begin
         if (irq_req[i] && {1'b0, irq_prio[4*i +: 3]} > best_lvl) begin
            best_lvl = {1'b0, irq_prio[4*i +: 3]};
            best_id  = 5'h08 + 5'(i);
            best_vld = 1'b1;
         end
      end
      for (int i = 0; i < 8; i++) begin
         if (trap_pend[i]) begin // RULE_16
            best_lvl = 4'h8 + 4'(i);
            best_id  = 5'(i);
            best_vld = 1'b1;
         end
      end
   end

   wire hard_pend = |trap_pend[7:4];
   wire accept    = state == TIS_RUN && eval_vld && instr_done &&
                    !return_from_interrupt_op &&
                    eval_lvl > cpu_priority_level; // RULE_20 RULE_07
   wire retire    = state == TIS_RUN && return_from_interrupt_op &&
                    !accept;
   wire [2:0] sp_dn = sp - 3'h1;

   // pin input: three stages, a change counts once stages two and
   // three agree
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         osc_sync <= 3'b000;
         osc_fail <= 1'b0;
      end else begin
         osc_sync <= {osc_sync[1:0], osc_fail_pin};
         if (osc_sync[2] == osc_sync[1])
            osc_fail <= osc_sync[2];
      end
   end

   // apb slave: one wait-free access phase
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup & ~sel_any;
         if (apb_setup)
            prdata <= pwrite ? 32'h00000000 : rd_mux;
      end
   end

   // reset cause flags survive the error reset; write one to clear,
   // a cause arriving together with the clear wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reset_control_reg <= 16'h0000;
         srst              <= 1'b0;
         core_rst_req      <= 1'b0;
      end else begin
         srst         <= err_rst;
         core_rst_req <= err_rst; // RULE_03
         reset_control_reg <=
            (reset_control_reg & ~((apb_wr & sel_rst) ? pwdata[15:0] :
                                   16'h0000)) |
            ({15'h0000, conflict} << `TIS_BIT_CONFLICT) | // RULE_17
            ({15'h0000, bad_op} << `TIS_BIT_BADOP) |
            ({15'h0000, wdt_timeout} << `TIS_BIT_WDT) |
            ({15'h0000, brown_out} << `TIS_BIT_BOR);
      end
   end

   // software registers; event sets beat software clears
   wire [15:0] ictl_clr = (apb_wr && sel_ictl) ? ~pwdata[15:0] :
                                                  16'h0000;
   wire [15:0] ictl_set = {11'h000, math_ev, addr_ev, stack_ev, osc_ev,
                           1'b0};
   wire [15:0] ictl_keep = {11'h000, math_ev, 2'b00, osc_fail, 1'b0};
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_control_one <= 16'h0000;
         irq_flag_regs         <= 8'h00;
         irq_enable_regs       <= 8'h00;
         irq_prio              <= `TIS_IPRIO_RST;
         stack_limit_reg       <= `TIS_STACK_LIMIT_REG_RST;
      end else if (srst) begin
         interrupt_control_one <= 16'h0000;
         irq_flag_regs         <= 8'h00;
         irq_enable_regs       <= 8'h00;
         irq_prio              <= `TIS_IPRIO_RST;
         stack_limit_reg       <= `TIS_STACK_LIMIT_REG_RST;
      end else begin
         if (apb_wr && sel_ictl)
            interrupt_control_one[15:5] <= pwdata[15:5];
         interrupt_control_one[4:0] <= (interrupt_control_one[4:0] &
            ~(ictl_clr[4:0] & ~ictl_keep[4:0])) |
            ictl_set[4:0]; // RULE_18
         irq_flag_regs <= (irq_flag_regs &
            ~((apb_wr && sel_iflag) ? pwdata[7:0] : 8'h00)) |
            irq_events; // RULE_19 RULE_23
         if (apb_wr && sel_ien)
            irq_enable_regs <= pwdata[7:0];
         if (apb_wr && sel_iprio)
            irq_prio <= pwdata & 32'h77777777;
         if (apb_wr && sel_stack_limit_reg)
            stack_limit_reg <= pwdata[15:0];
      end
   end

   // sample stage: requests are ranked one cycle, taken the next
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         eval_lvl <= 4'h0;
         eval_id  <= 5'h00;
         eval_vld <= 1'b0;
      end else if (srst || accept) begin
         eval_lvl <= 4'h0;
         eval_id  <= 5'h00;
         eval_vld <= 1'b0;
      end else begin
         eval_lvl <= best_lvl; // RULE_13 RULE_15
         eval_id  <= best_id;
         eval_vld <= best_vld;
      end
   end

   // pending traps stay until their own acceptance
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         trap_pend <= 8'h00;
      else if (srst)
         trap_pend <= 8'h00;
      else
         trap_pend <= (trap_pend & ~((accept && !eval_id[3]) ?
                      (8'h01 << eval_id[2:0]) : 8'h00)) |
                      new_trap; // RULE_15 RULE_16
   end

   // level stack, so a return restores the level it interrupted
   always_ff @(posedge mclk) begin
      if (accept) begin
         stk_pc[sp]  <= cur_pc;
         stk_lvl[sp] <= cpu_priority_level;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state              <= TIS_F0;
         cpu_priority_level <= 4'h0;
         sp                 <= 3'h0;
         fetch_req          <= 1'b0;
         fetch_addr         <= `TIS_BOOT_ADDR0;
         pc_load            <= 1'b0;
         pc_value           <= 24'h000000;
         exc_take           <= 1'b0;
         exc_vector         <= 5'h00;
         push_req           <= 1'b0;
         push_pc            <= 24'h000000;
         push_srl           <= 8'h00;
         cpu_halt           <= 1'b0;
      end else if (srst) begin
         state              <= TIS_F0; // RULE_01
         cpu_priority_level <= 4'h0;
         sp                 <= 3'h0;
         fetch_req          <= 1'b0;
         fetch_addr         <= `TIS_BOOT_ADDR0;
         pc_load            <= 1'b0;
         pc_value           <= 24'h000000;
         exc_take           <= 1'b0;
         exc_vector         <= 5'h00;
         push_req           <= 1'b0;
         push_pc            <= 24'h000000;
         push_srl           <= 8'h00;
         cpu_halt           <= 1'b0;
      end else begin
         pc_load  <= 1'b0;
         exc_take <= 1'b0;
         push_req <= 1'b0;
         cpu_halt <= state == TIS_RUN && (hard_pend ||
                     |new_trap[7:4]) && !accept; // RULE_14
         case (state)
            TIS_F0: begin
               fetch_req  <= 1'b1; // RULE_01
               fetch_addr <= `TIS_BOOT_ADDR0;
               if (fetch_valid && fetch_req) begin
                  state      <= TIS_F1;
                  fetch_addr <= `TIS_BOOT_ADDR1;
               end
            end
            TIS_F1: begin
               if (fetch_valid && fetch_addr == `TIS_BOOT_ADDR1) begin
                  state     <= TIS_RUN;
                  fetch_req <= 1'b0;
                  pc_load   <= 1'b1; // RULE_02
                  pc_value  <= fetch_data;
               end
            end
            TIS_RUN: begin
               if (accept) begin
                  exc_take           <= 1'b1; // RULE_21
                  exc_vector         <= eval_id;
                  push_req           <= 1'b1;
                  push_pc            <= cur_pc;
                  push_srl           <= {4'h0, cpu_priority_level};
                  cpu_priority_level <= eval_lvl; // RULE_05 RULE_22
                  sp                 <= sp + 3'h1;
               end else if (retire) begin
                  cpu_priority_level <= stk_lvl[sp_dn]; // RULE_23
                  pc_load            <= 1'b1;
                  pc_value           <= stk_pc[sp_dn];
                  sp                 <= sp_dn;
               end else if (apb_wr && sel_core) begin
                  // trap bit is hardware owned
                  cpu_priority_level <= {cpu_priority_level[3],
                                         pwdata[2:0]}; // RULE_06
               end
            end
            default: state <= TIS_F0;
         endcase
      end
   end

endmodule : tis_core

//--- tis_core_properties.sv
// concurrent checks on the sequencer ports
`timescale 1ns/1ps
module tis_core_properties (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        fetch_req,
   input wire logic [23:0] fetch_addr,
   input wire logic        fetch_valid,
   input wire logic [23:0] fetch_data,
   input wire logic        pc_load,
   input wire logic [23:0] pc_value,
   input wire logic        wdt_timeout,
   input wire logic        brown_out,
   input wire logic        uninit_ptr,
   input wire logic        core_rst_req,
   input wire logic        instr_done,
   input wire logic        exc_take,
   input wire logic        push_req,
   input wire logic [23:0] push_pc,
   input wire logic [23:0] cur_pc,
   input wire logic        return_from_interrupt_op
);
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   AST_APB_READY:
      assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   AST_BOOT_ZERO:
      assert property ($rose(fetch_req) |-> fetch_addr == 24'h000000)
      else $error("boot fetch not at zero");
   AST_BOOT_JUMP:
      assert property (fetch_req && fetch_valid && fetch_addr == 24'h000002
         |=> pc_load && pc_value == $past(fetch_data) && !fetch_req)
      else $error("boot target not loaded");
   AST_ERR_RESET:
      assert property (wdt_timeout || brown_out || uninit_ptr |=> core_rst_req)
      else $error("error reset not taken");
   AST_REBOOT:
      assert property (core_rst_req
         |-> ##[0:3] fetch_req && fetch_addr == 24'h000000)
      else $error("no refetch from zero");
   AST_ON_BOUNDARY:
      assert property (exc_take |-> $past(instr_done))
      else $error("exception taken off a boundary");
   AST_PUSH_FRAME:
      assert property (exc_take |-> push_req && push_pc == $past(cur_pc))
      else $error("stack frame not pushed");
   AST_RETURN_POP:
      assert property (return_from_interrupt_op |=> pc_load)
      else $error("return did not reload pc");
endmodule : tis_core_properties

bind tis_core tis_core_properties i_props (
   .mclk, .rst_n, .psel, .penable, .pready, .fetch_req, .fetch_addr,
   .fetch_valid, .fetch_data, .pc_load, .pc_value, .wdt_timeout,
   .brown_out, .uninit_ptr, .core_rst_req, .instr_done, .exc_take,
   .push_req, .push_pc, .cur_pc, .return_from_interrupt_op
);

//--- tis_pipe_model.sv
// pipeline stand-in: answers boot fetches, reports instruction boundaries
`timescale 1ns/1ps
module tis_pipe_model #(
   parameter logic [23:0] TARGET = 24'h000100,
   // jump opcode word, value arbitrary
   parameter logic [23:0] JUMP   = 24'h5A0000
) (
   input  wire logic        mclk,
   input  wire logic        rst_n,
   input  wire logic        slow,
   input  wire logic        fetch_req,
   input  wire logic [23:0] fetch_addr,
   input  wire logic        pc_load,
   input  wire logic [23:0] pc_value,
   input  wire logic        cpu_halt,
   input  wire logic        core_rst_req,
   output logic             fetch_valid,
   output logic      [23:0] fetch_data,
   output logic             instr_done,
   output logic      [23:0] cur_pc
);
   logic [1:0] lag;
   logic       run;
   wire        give = fetch_req && !fetch_valid && (!slow || lag == 2'h3);
   wire        live = !core_rst_req && (run || pc_load);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         {fetch_valid, lag, run, instr_done, cur_pc} <= '0;
         fetch_data <= 24'hA5A5A5;
      end else begin
         lag <= (fetch_req && !fetch_valid) ? lag + 2'h1 : 2'h0;
         fetch_valid <= give;
         // idle bus toggles so stale data never looks valid
         fetch_data <= give ? ((fetch_addr == 24'h0) ? JUMP : TARGET)
                            : ~fetch_data;
         run <= live;
         // a halted core still reports the boundary of the trapping op
         instr_done <= live && !(slow && instr_done);
         if (pc_load)
            cur_pc <= pc_value;
         else if (instr_done && !cpu_halt)
            cur_pc <= cur_pc + 24'h2;
      end
   end
endmodule : tis_pipe_model

//--- trap_and_interrupt_sequencer_bench.sv
// self-checking bench for the trap and interrupt sequencer
`timescale 1ns/1ps
module trap_and_interrupt_sequencer_bench;
   localparam logic [23:0] TARGET = 24'h000100;
   logic        mclk, rst_n, psel, penable, pwrite, slow, er, halted;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, op_flushed, acc_guard_used, sat_off;
   logic        osc_fail_pin, fetch_valid, instr_done, fetch_req, pc_load;
   logic        exc_take, push_req, cpu_halt, core_rst_req;
   logic [13:0] ev;
   logic [13:0] tm [10];
   logic [15:0] sp_value;
   logic [7:0]  irq_events, push_srl;
   logic [23:0] cur_pc, fetch_data, fetch_addr, pc_value, push_pc;
   logic [4:0]  exc_vector;
   logic [3:0]  lv;
   wire  [1:0]  acc_ovf31, acc_ovf39;
   wire         div_zero, shift_over, misaligned, unimpl_read, vector_fetch;
   wire         unimpl_branch, sp_load, wdt_timeout, uninit_ptr, brown_out;
   wire         illegal_op, return_from_interrupt_op;
   int          bad_count, total_checks, takes, rsts, cyc, i;

   assign {return_from_interrupt_op, illegal_op, brown_out, uninit_ptr,
           wdt_timeout, sp_load, unimpl_branch, vector_fetch, unimpl_read,
           misaligned, shift_over, div_zero} = ev[11:0];
   assign acc_ovf31 = {1'b0, ev[12]};
   assign acc_ovf39 = {ev[13], 1'b0};

   tis_core i_dut (
      .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .instr_done, .cur_pc, .fetch_valid, .fetch_data,
      .return_from_interrupt_op, .div_zero, .acc_ovf31, .acc_guard_used,
      .acc_ovf39, .sat_off, .shift_over, .misaligned, .unimpl_read,
      .vector_fetch, .unimpl_branch, .sp_load, .sp_value, .osc_fail_pin,
      .wdt_timeout, .uninit_ptr, .illegal_op, .op_flushed, .brown_out,
      .irq_events, .fetch_req, .fetch_addr, .pc_load, .pc_value, .exc_take,
      .exc_vector, .push_req, .push_pc, .push_srl, .cpu_halt, .core_rst_req
   );
   tis_pipe_model #(.TARGET(TARGET)) i_pipe (
      .mclk, .rst_n, .slow, .fetch_req, .fetch_addr, .pc_load, .pc_value,
      .cpu_halt, .core_rst_req, .fetch_valid, .fetch_data, .instr_done,
      .cur_pc
   );

   always #4 mclk = ~mclk;

   always @(posedge mclk) begin
      takes <= takes + int'(exc_take === 1'b1);
      rsts <= rsts + int'(core_rst_req === 1'b1);
      if (cpu_halt === 1'b1)
         halted <= 1'b1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         final_report();
      end
   end

   task final_report;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk

   // caller stands just after a rising edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask : apb

   task rdc(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdc

   task pulse(input logic [13:0] m);
      ev <= m;
      @(posedge mclk);
      ev <= '0;
      @(posedge mclk);
   endtask : pulse

   // take one exception, clear its flag, return, check the pop
   task serve(input logic [4:0] v, input logic [7:0] s, input logic [3:0] l,
              input logic [11:0] ca, input logic [31:0] cd);
      int          t0;
      logic [23:0] pp;
      while (exc_take !== 1'b1) @(posedge mclk);
      t0 = takes;
      pp = push_pc;
      chk(exc_vector, v);
      chk(push_srl, s);
      rdc(12'h000, {28'h0, l});
      apb(1'b1, ca, cd);
      chk(takes, t0 + 1);
      pulse(14'h0800);
      while (pc_load !== 1'b1) @(posedge mclk);
      chk(pc_value, pp);
   endtask : serve

   task reset_case(input logic [13:0] m, input logic [31:0] flag);
      pulse(m);
      while (core_rst_req !== 1'b1) @(posedge mclk);
      while (pc_load !== 1'b1) @(posedge mclk);
      chk(pc_value, TARGET);
      rdc(12'h018, flag);
      apb(1'b1, 12'h018, flag);
      rdc(12'h018, 32'h0);
   endtask : reset_case

   initial begin
      {mclk, rst_n, psel, penable, pwrite, slow, halted} = '0;
      {paddr, pwdata, ev, sp_value, irq_events} = '0;
      {op_flushed, acc_guard_used, osc_fail_pin} = '0;
      sat_off = 1'b1;
      {bad_count, total_checks, takes, rsts, cyc} = '0;
      tm = '{14'h0001, 14'h0002, 14'h1000, 14'h2000, 14'h0004, 14'h0008,
             14'h0010, 14'h0020, 14'h0040, 14'h0040};
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      while (pc_load !== 1'b1) @(posedge mclk);
      chk(pc_value, TARGET);
      rdc(12'h010, 32'h44444444);
      rdc(12'h014, 32'h0000FFFF);
      rdc(12'h020, 32'h0);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, 12'h014, 32'h1000);
      apb(1'b1, 12'h004, 32'h700);
      for (i = 0; i < 2; i++) begin
         sp_value <= (i == 0) ? 16'h0800 : 16'h1000;
         pulse(14'h0040);
      end
      repeat (6) @(posedge mclk);
      chk(takes, 0);
      for (i = 0; i < 10; i++) begin
         lv = (i < 4) ? 4'hB : (i < 8) ? 4'hC : 4'hD;
         sp_value <= (i == 8) ? 16'h07FE : 16'h1002;
         slow <= (i > 4);
         halted <= 1'b0;
         pulse(tm[i]);
         serve({1'b0, lv - 4'h8}, 8'h00, lv, 12'h004, 32'h700);
         chk({31'h0, halted}, {31'h0, lv > 4'hB});
         rdc(12'h004, 32'h700);
      end
      slow <= 1'b0;
      acc_guard_used <= 1'b1;
      pulse(14'h1000);
      apb(1'b1, 12'h004, 32'h0);
      pulse(14'h3000);
      repeat (6) @(posedge mclk);
      chk(takes, 10);
      pulse(14'h0005);
      serve(5'h4, 8'h00, 4'hC, 12'h004, 32'h10);
      serve(5'h3, 8'h00, 4'hB, 12'h004, 32'h0);
      apb(1'b1, 12'h00C, 32'h3);
      irq_events <= 8'h03;
      @(posedge mclk);
      irq_events <= 8'h00;
      serve(5'h8, 8'h00, 4'h4, 12'h008, 32'h1);
      serve(5'h9, 8'h00, 4'h4, 12'h008, 32'h2);
      apb(1'b1, 12'h010, 32'h44444447);
      apb(1'b1, 12'h000, 32'h7);
      irq_events <= 8'h01;
      @(posedge mclk);
      irq_events <= 8'h00;
      repeat (6) @(posedge mclk);
      chk(takes, 14);
      pulse(14'h0001);
      serve(5'h3, 8'h07, 4'hB, 12'h004, 32'h0);
      apb(1'b1, 12'h000, 32'h0);
      serve(5'h8, 8'h00, 4'h7, 12'h008, 32'h1);
      rdc(12'h000, 32'h0);
      osc_fail_pin <= 1'b1;
      serve(5'h6, 8'h00, 4'hE, 12'h004, 32'h0);
      rdc(12'h004, 32'h2);
      osc_fail_pin <= 1'b0;
      repeat (5) @(posedge mclk);
      apb(1'b1, 12'h004, 32'h0);
      rdc(12'h004, 32'h0);
      op_flushed <= 1'b1;
      pulse(14'h0400);
      repeat (6) @(posedge mclk);
      chk(rsts, 0);
      op_flushed <= 1'b0;
      sp_value <= 16'h07FE;
      reset_case(14'h0080, 32'h10);
      reset_case(14'h0100, 32'h4000);
      reset_case(14'h0200, 32'h2);
      reset_case(14'h0400, 32'h4000);
      // stack trap pending, then a lower address trap: conflict
      pulse(14'h0040);
      reset_case(14'h0004, 32'h8000);
      final_report();
   end
endmodule : trap_and_interrupt_sequencer_bench
